/* rtl/adcprs_top.v */
`timescale 1ns/1ps
`include "adcprs_consts.vh"

// Summary of operation
// [RL1] write and read strobes count only while device select is low.
// [RL2] host decodes its address lines to make the device select.
// [RL3] track mode from done flag rising until a new conversion starts; here track resumes when the result enters the buffer.
// [RL4] selected write starts conversion; write rising edge enters hold.
// [RL5] in hold, conversion steps run from own clock without host help.
// [RL6] result goes to output latch, then done flag is driven low; here the result enters the buffer and the latch loads on a selected read.
// [RL7] selected read raises done flag and puts the result on the bus; here each popping read pulses the flag high; it stays high once the buffer empties.
// [RL8] conversion completes within 6 microseconds.
// [RL9] 10-bit result on 3-state bus, released outside a selected read.
module adcprs_top #(
  parameter RES_W = `ADCPRS_RES_W,
  parameter STEP_CYC = `ADCPRS_STEP_CYC
)
(
  // clock and reset
  input wire MCLK_I,
  input wire RST_N_I,
  // host bus strobes, active low, asynchronous pins
  input wire CS_N_I,
  input wire WR_N_I,
  input wire RD_N_I,
  // comparator decision from analog core
  input wire CMP_I,
  // trial code to the capacitor array and hold control
  output wire [RES_W-1:0] DAC_CODE_O,
  output wire HOLD_O,
  // result bus as one data signal per pin and one output enable shared by all pins
  output wire [RES_W-1:0] DATA_O,
  output wire DATA_OE_O,
  // end-of-conversion flag, active low
  output wire EOC_N_O
);

  // ==========================================================
  // input synchronisers
  reg [1:0] cs_sync;
  reg [1:0] wr_sync;
  reg [1:0] rd_sync;
  reg [1:0] cmp_sync;
  reg wr_last;
  reg rd_sel_last;
  wire cs_sel;
  wire wr_sel;
  wire rd_sel;
  wire wr_rise;
  wire rd_fall;

  // metastability guard: each strobe edge costs two cycles of latency,
  // so the host must hold every strobe for three clocks or more
  // two stages each; only bit 1 is read by logic
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      cs_sync <= `ADCPRS_SYNC_HI;
      wr_sync <= `ADCPRS_SYNC_HI;
      rd_sync <= `ADCPRS_SYNC_HI;
      cmp_sync <= `ADCPRS_SYNC_LO;
      wr_last <= 1'b0;
      rd_sel_last <= 1'b0;
    end
    else
    begin
      cs_sync <= {cs_sync[0], CS_N_I};
      wr_sync <= {wr_sync[0], WR_N_I};
      rd_sync <= {rd_sync[0], RD_N_I};
      cmp_sync <= {cmp_sync[0], CMP_I};
      wr_last <= wr_sel;
      rd_sel_last <= rd_sel;
    end
  end

  assign cs_sel = ~cs_sync[1];
  assign wr_sel = cs_sel & ~wr_sync[1]; // RL1
  assign rd_sel = cs_sel & ~rd_sync[1]; // RL1
  // edge flops reset to the idle level, so no false edge
  // follows the release of reset
  // end of selected write pulse starts hold
  assign wr_rise = wr_last & ~wr_sel; // RL4
  assign rd_fall = rd_sel & ~rd_sel_last; // RL7

  // ==========================================================
  // conversion sequencer
  reg [1:0] state;
  reg [1:0] next_state;
  reg [RES_W-1:0] sar;
  reg [RES_W-1:0] trial;
  reg [`ADCPRS_STEP_W-1:0] bit_cnt;
  reg [7:0] step_cnt;
  reg hold;
  wire step_done;
  wire buf_in_ready;

  // ten steps of STEP_CYC must fit the conversion bound, so keep
  // STEP_CYC at 11 or less
  assign step_done = (step_cnt == STEP_CYC[7:0] - 8'h01);

  // next state; a start during a conversion is ignored
  always @*
  begin
    next_state = state;
    case (state)
      `ADCPRS_ST_TRACK:
        if (wr_rise)
          next_state = `ADCPRS_ST_CONV; // RL4
      `ADCPRS_ST_CONV:
        if (step_done && bit_cnt == {`ADCPRS_STEP_W{1'b0}})
          next_state = `ADCPRS_ST_LOAD;
      `ADCPRS_ST_LOAD:
        // a third result waits here with hold high; the host
        // must read before starting more than two conversions
        // stalls here while the result buffer is full
        if (buf_in_ready)
          next_state = `ADCPRS_ST_TRACK; // RL3
      default:
        next_state = `ADCPRS_ST_TRACK;
    endcase
  end

  // successive approximation, one bit per step, MSB first
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      state <= `ADCPRS_ST_TRACK;
      sar <= `ADCPRS_RES_RST;
      trial <= `ADCPRS_RES_RST;
      bit_cnt <= {`ADCPRS_STEP_W{1'b0}};
      step_cnt <= 8'h00;
      hold <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == `ADCPRS_ST_TRACK && wr_rise)
      begin
        hold <= 1'b1; // RL4
        sar <= `ADCPRS_ZERO_W;
        trial <= `ADCPRS_MSB_BIT;
        bit_cnt <= RES_W[`ADCPRS_STEP_W-1:0] - 4'h1;
        step_cnt <= 8'h00;
      end
      else if (state == `ADCPRS_ST_CONV)
      begin
        // the comparator passes two flops, so a step shorter than
        // three cycles would judge the previous trial
        // self-timed from MCLK_I, no host action
        if (step_done) // RL5
        begin
          step_cnt <= 8'h00;
          if (cmp_sync[1])
            sar <= sar | trial;
          trial <= trial >> 1;
          bit_cnt <= bit_cnt - 4'h1;
        end
        else
          step_cnt <= step_cnt + 8'h01; // RL8
      end
      else if (state == `ADCPRS_ST_LOAD && buf_in_ready)
        hold <= 1'b0; // RL3
    end
  end

  assign DAC_CODE_O = sar | trial;
  assign HOLD_O = hold;

  // ==========================================================
  // result buffer; a result not yet read is kept, not overwritten
  wire buf_out_valid;
  wire [RES_W-1:0] buf_out_data;
  wire buf_pop;

  // a push and a pop may meet in one cycle; the buffer takes both unless full, when only the pop is taken
  assign buf_pop = rd_fall & buf_out_valid;

  adcprs_buf2 #(
    .W(RES_W)
  ) adcprs_buf2_i (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(state == `ADCPRS_ST_LOAD),
    .in_ready_o(buf_in_ready),
    .in_data_i(sar),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out_data)
  );

  // ==========================================================
  // output latch and done flag
  reg [RES_W-1:0] out_latch;
  reg eoc_n;
  reg oe;

  // one read pops one word; a strobe held low pops no more
  // latch taken on the read edge; flag low means a word waits
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      out_latch <= `ADCPRS_RES_RST;
      eoc_n <= 1'b1;
      oe <= 1'b0;
    end
    else
    begin
      oe <= rd_sel; // RL9
      if (buf_pop)
        out_latch <= buf_out_data; // RL7
      // flag follows buffer: low one cycle after the word is stored
      eoc_n <= ~(buf_out_valid & ~buf_pop); // RL6
    end
  end

  // high impedance whenever no selected read is active
  assign DATA_O = out_latch; // RL9
  assign DATA_OE_O = oe; // RL9
  assign EOC_N_O = eoc_n; // RL7

endmodule

/* rtl/adcprs_consts.vh */
`ifndef ADCPRS_CONSTS_VH
`define ADCPRS_CONSTS_VH

// result width and width of the successive-approximation step counter
`define ADCPRS_RES_W 10
`define ADCPRS_STEP_W 4
// conversion time in ns and clock period in ns (20 MHz)
`define ADCPRS_CONV_NS 6000
`define ADCPRS_CLK_NS 50
// cycles per approximation step, rounded down so the whole fits the bound
`define ADCPRS_STEP_CYC ((`ADCPRS_CONV_NS / `ADCPRS_CLK_NS) / 12)
// reset values and the first trial bit
`define ADCPRS_RES_RST 10'h000
`define ADCPRS_ZERO_W 10'h000
`define ADCPRS_MSB_BIT 10'h200
// synchroniser reset values, at the idle level of each pin
`define ADCPRS_SYNC_HI 2'h3
`define ADCPRS_SYNC_LO 2'h0
// state codes
`define ADCPRS_ST_TRACK 2'h0
`define ADCPRS_ST_CONV 2'h1
`define ADCPRS_ST_LOAD 2'h2

`endif

/* rtl/adcprs_buf2.v */
`timescale 1ns/1ps
`include "adcprs_consts.vh"

module adcprs_buf2 #(
  parameter W = `ADCPRS_RES_W
)
(
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);

  // ==========================================================
  // two-entry storage
  reg [W-1:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire do_wr;
  wire do_rd;

  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = mem[rd_ptr];
  assign do_wr = in_valid_i & in_ready_o;
  assign do_rd = out_valid_o & out_ready_i;

  // pointers and fill count; both sides may move in one cycle
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      mem[0] <= `ADCPRS_ZERO_W;
      mem[1] <= `ADCPRS_ZERO_W;
    end
    else
    begin
      if (do_wr)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= ~wr_ptr;
      end
      if (do_rd)
        rd_ptr <= ~rd_ptr;
      if (do_wr && !do_rd)
        count <= count + 2'h1;
      else if (do_rd && !do_wr)
        count <= count - 2'h1;
    end
  end

endmodule

/* testbench/adcprs_checker.sv */
`timescale 1ns/1ps
// ==========
// port checks
module adcprs_checker #(
  parameter RES_W = 10
)
(
  // clock, reset, host strobes
  input wire MCLK_I,
  input wire RST_N_I,
  input wire CS_N_I,
  input wire WR_N_I,
  input wire RD_N_I,
  // sequencer outputs
  input wire [RES_W-1:0] DAC_CODE_O,
  input wire HOLD_O,
  input wire DATA_OE_O,
  input wire EOC_N_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  wire rd_sel = !CS_N_I && !RD_N_I;
  // selected write: strobe low, then released with select still low
  sequence s_wr;
    !CS_N_I && !WR_N_I ##1 !CS_N_I && WR_N_I;
  endsequence
  // slack of one cycle, as the strobes pass a synchroniser
  a_oe_cause: assert property (DATA_OE_O |-> $past(rd_sel, 2) ||
    $past(rd_sel, 3)) else $error("bus driven outside read");
  a_oe_on_read: assert property (rd_sel[*4] |-> DATA_OE_O)
    else $error("read not driven");
  a_wr_start: assert property (s_wr ##0 !HOLD_O |-> ##[1:4] HOLD_O)
    else $error("write did not hold");
  a_unsel_idle: assert property (CS_N_I[*6] |=> !$rose(HOLD_O))
    else $error("hold without select");
  a_track_stays: assert property ((!HOLD_O && WR_N_I)[*5] |=> !HOLD_O)
    else $error("left track alone");
  a_conv_bound: assert property ($rose(HOLD_O) |-> ##[1:117]
    $fell(HOLD_O)) else $error("conversion too long");
  a_eoc_after: assert property ($fell(HOLD_O) |-> ##[0:3] !EOC_N_O)
    else $error("no done flag");
  a_dac_msb: assert property ($rose(HOLD_O) |-> DAC_CODE_O == 10'h200)
    else $error("first trial not msb");
endmodule
bind adcprs_top adcprs_checker #(.RES_W(RES_W)) adcprs_checker_i (.*);

/* testbench/adcprs_cmp_model.sv */
`timescale 1ns/1ps
// ==========
// analog core stand-in
module adcprs_cmp_model (
  // trial code and held input
  input wire [9:0] code_i,
  input wire [9:0] level_i,
  // decision
  output logic keep_o
);
  // keep the trial bit while the input is not below it
  assign keep_o = (code_i <= level_i);
endmodule

/* testbench/test_adcprs_top.sv */
`timescale 1ns/1ps
// ==========
// bench
module test_adcprs_top;
  logic MCLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic CS_N_I = 1'b1;
  logic WR_N_I = 1'b1;
  logic RD_N_I = 1'b1;
  logic [9:0] level = 10'h000;
  wire CMP_I, HOLD_O, DATA_OE_O, EOC_N_O;
  wire [9:0] DAC_CODE_O, DATA_O;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  adcprs_top adcprs_top_i (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
    .CS_N_I(CS_N_I), .WR_N_I(WR_N_I), .RD_N_I(RD_N_I), .CMP_I(CMP_I),
    .DAC_CODE_O(DAC_CODE_O), .HOLD_O(HOLD_O), .DATA_O(DATA_O),
    .DATA_OE_O(DATA_OE_O), .EOC_N_O(EOC_N_O));
  adcprs_cmp_model adcprs_cmp_model_i (.code_i(DAC_CODE_O),
    .level_i(level), .keep_o(CMP_I));
  // clock
  initial
  begin
    forever #25 MCLK_I = ~MCLK_I;
  end
  // hang guard, far above the tests' length
  always @(posedge MCLK_I)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge MCLK_I);
  endtask
  // strobes held 4 cycles, beyond the synchroniser's need
  task automatic write(input logic sel_n);
    CS_N_I = sel_n;
    WR_N_I = 1'b0;
    cycles(4);
    WR_N_I = 1'b1;
    cycles(1);
    CS_N_I = 1'b1;
    cycles(1);
  endtask
  task automatic read(input logic sel_n, input logic [9:0] e);
    CS_N_I = sel_n;
    RD_N_I = 1'b0;
    cycles(4);
    chk("oe", {9'h0, !sel_n}, {9'h0, DATA_OE_O});
    if (!sel_n) chk("data", e, DATA_O);
    RD_N_I = 1'b1;
    CS_N_I = 1'b1;
    cycles(4);
    chk("oe off", 10'h0, {9'h0, DATA_OE_O});
  endtask
  // done flag within 120 cycles of the write edge; callers have spent
  // 2 to 4 cycles since that edge, so 116 more is the safe bound
  task automatic wait_eoc();
    int n;
    n = 0;
    while (EOC_N_O !== 1'b0 && n < 125)
    begin
      cycles(1);
      n++;
    end
    chk("conv time", 10'h1, {9'h0, n <= 116});
  endtask
  task automatic t_unsel();
    write(1'b1);
    cycles(10);
    chk("hold", 10'h0, {9'h0, HOLD_O});
    read(1'b1, 10'h0);
    $display("t_unsel done");
  endtask
  task automatic t_convert();
    logic [9:0] lv [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
    foreach (lv[k])
    begin
      level = lv[k];
      write(1'b0);
      cycles(2);
      chk("hold", 10'h1, {9'h0, HOLD_O});
      wait_eoc();
      read(1'b0, lv[k]);
      chk("eoc", 10'h1, {9'h0, EOC_N_O});
    end
    $display("t_convert done");
  endtask
  // second word lands while the first stays unread
  task automatic t_buffer();
    level = 10'h0F0;
    write(1'b0);
    wait_eoc();
    level = 10'h30F;
    write(1'b0);
    cycles(118);
    read(1'b0, 10'h0F0);
    chk("eoc", 10'h0, {9'h0, EOC_N_O});
    read(1'b0, 10'h30F);
    chk("eoc", 10'h1, {9'h0, EOC_N_O});
    $display("t_buffer done");
  endtask
  // reset in mid-conversion drops hold, leaves the flag high and clears the latch
  task automatic t_reset();
    level = 10'h2C3;
    write(1'b0);
    cycles(20);
    RST_N_I = 1'b0;
    cycles(4);
    RST_N_I = 1'b1;
    cycles(1);
    chk("hold rst", 10'h0, {9'h0, HOLD_O});
    chk("eoc rst", 10'h1, {9'h0, EOC_N_O});
    chk("data rst", 10'h0, DATA_O);
    write(1'b0);
    wait_eoc();
    read(1'b0, 10'h2C3);
    $display("t_reset done");
  endtask
  initial
  begin
    cycles(4);
    RST_N_I = 1'b1;
    cycles(1);
    t_unsel();
    t_convert();
    t_buffer();
    t_reset();
    print_verdict();
  end
endmodule
